// file: core/cwpu_pkg.sv
// cwpu_pkg: field layout, reset values and decode tables of the two
// configuration words. assumes nothing beyond a SystemVerilog compiler.
package cwpu_pkg;
    localparam int unsigned CWPU_WORD_W        = 32;
    // first word: clock multiplier defaults
    localparam int unsigned CWPU_ODIV_LSB      = 16;
    localparam int unsigned CWPU_UBYP_BIT      = 15;
    localparam int unsigned CWPU_UIDIV_LSB     = 8;
    localparam int unsigned CWPU_MUL_LSB       = 4;
    localparam int unsigned CWPU_MIDIV_LSB     = 0;
    localparam int unsigned CWPU_SEL_W         = 3;
    localparam logic [31:0] CWPU_W2_RSVD_MASK  = 32'hfff8_7888;
    // second word: pin owners, lock policy, identifier
    localparam int unsigned CWPU_VBUS_BIT      = 31;
    localparam int unsigned CWPU_CID_BIT       = 30;
    localparam int unsigned CWPU_REMAP1_BIT    = 29;
    localparam int unsigned CWPU_MODDIS1_BIT   = 28;
    localparam int unsigned CWPU_UID_LSB       = 0;
    localparam int unsigned CWPU_UID_W         = 16;
    localparam logic [31:0] CWPU_W3_RSVD_MASK  = 32'h0fff_0000;
    // erased-state reset value: every bit reads one until sampled
    localparam logic [31:0] CWPU_WORD_RST      = 32'hffff_ffff;
    localparam int unsigned CWPU_RATIO_W       = 9;
    typedef logic [CWPU_RATIO_W-1:0] cwpu_ratio_t;
    typedef cwpu_ratio_t cwpu_tab_t [8];
    localparam cwpu_tab_t CWPU_ODIV_TAB = '{9'h001, 9'h002, 9'h004, 9'h008,
                                            9'h010, 9'h020, 9'h040, 9'h100};
    localparam cwpu_tab_t CWPU_IDIV_TAB = '{9'h001, 9'h002, 9'h003, 9'h004,
                                            9'h005, 9'h006, 9'h00a, 9'h00c};
    localparam cwpu_tab_t CWPU_MUL_TAB  = '{9'h00f, 9'h010, 9'h011, 9'h012,
                                            9'h013, 9'h014, 9'h015, 9'h018};
    localparam logic [1:0] CWPU_LOAD_RST = 2'h0;
    localparam logic [1:0] CWPU_LOAD_DONE = 2'h1;
endpackage

// file: core/cwpu_core.sv
// cwpu_core: samples the two configuration words once after reset, holds
// the decoded clock, pin-owner, lock-policy and identifier fields, and
// gates writes to the remap and module-disable registers by their locks.
// assumes the configuration words are stable from reset release onward.
//
// Operation
// - output divisor 1..64,256 by 3-bit code
// - usb bypass bit one disables multiplier
// - usb input divider 1..6,10,12
// - main multiplier 15..21,24
// - main input divider 1..6,10,12
// - usb fields only on usb variant
// - bit 31 gives usb bus-power pin
// - bit 30 gives usb cable-id pin
// - bit 29 allows single remap reconfiguration
// - bit 28 allows single module-disable reconfiguration
// - low 16 bits user identifier readable
// - remap lock rejects remap writes
// - module lock rejects module-disable writes
`timescale 1ns/1ps
module cwpu_core
    import cwpu_pkg::*;
#(
    parameter bit HAS_USB = 1'b1
)
(
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_n,
    input  wire logic [cwpu_pkg::CWPU_WORD_W-1:0] i_cfg_word_clk,
    input  wire logic [cwpu_pkg::CWPU_WORD_W-1:0] i_cfg_word_pins,
    input  wire logic                          i_remap_lock_wr,
    input  wire logic                          i_remap_lock_val,
    input  wire logic                          i_moddis_lock_wr,
    input  wire logic                          i_moddis_lock_val,
    input  wire logic                          i_remap_wr,
    input  wire logic                          i_moddis_wr,
    output logic                               o_cfg_valid,
    output logic [cwpu_pkg::CWPU_WORD_W-1:0]   o_config_word_clock_multipliers,
    output logic [cwpu_pkg::CWPU_WORD_W-1:0]   o_config_word_usb_pins_locks_user_identifier,
    output cwpu_pkg::cwpu_ratio_t              o_main_mult_out_divisor,
    output cwpu_pkg::cwpu_ratio_t              o_main_mult_factor,
    output cwpu_pkg::cwpu_ratio_t              o_main_mult_in_divider,
    output logic                               o_usb_mult_bypass,
    output cwpu_pkg::cwpu_ratio_t              o_usb_mult_in_divider,
    output logic                               o_bus_power_pin_owner,
    output logic                               o_cable_id_pin_owner,
    output logic                               o_remap_single_config,
    output logic                               o_moddis_single_config,
    output logic [cwpu_pkg::CWPU_UID_W-1:0]    o_user_identifier,
    output logic                               o_remap_lock,
    output logic                               o_module_disable_lock,
    output logic                               o_remap_wr_ok,
    output logic                               o_moddis_wr_ok
);
    import cwpu_pkg::*;

    logic [1:0]             load_r;
    logic [CWPU_WORD_W-1:0] w2_r;
    logic [CWPU_WORD_W-1:0] w3_r;
    logic                   remap_lock_r;
    logic                   moddis_lock_r;
    logic                   remap_used_r;
    logic                   moddis_used_r;
    logic [CWPU_SEL_W-1:0]  odiv_sel;
    logic [CWPU_SEL_W-1:0]  uidiv_sel;
    logic [CWPU_SEL_W-1:0]  mul_sel;
    logic [CWPU_SEL_W-1:0]  midiv_sel;

    // words caught by a clock edge after release, never under reset
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            load_r <= CWPU_LOAD_RST;
            w2_r   <= CWPU_WORD_RST;
            w3_r   <= CWPU_WORD_RST;
        end
        else if (load_r == CWPU_LOAD_RST)
        begin
            load_r <= CWPU_LOAD_DONE;
            w2_r   <= i_cfg_word_clk;
            w3_r   <= i_cfg_word_pins;
        end
    end

    assign o_cfg_valid = (load_r == CWPU_LOAD_DONE);
    // reserved bits are reported as stored; a programmer that broke the
    // write-ones convention shows up here, the decode ignores them
    assign o_config_word_clock_multipliers     = w2_r;
    assign o_config_word_usb_pins_locks_user_identifier = w3_r;

    assign odiv_sel  = w2_r[CWPU_ODIV_LSB  +: CWPU_SEL_W];
    assign uidiv_sel = w2_r[CWPU_UIDIV_LSB +: CWPU_SEL_W];
    assign mul_sel   = w2_r[CWPU_MUL_LSB   +: CWPU_SEL_W];
    assign midiv_sel = w2_r[CWPU_MIDIV_LSB +: CWPU_SEL_W];

    assign o_main_mult_out_divisor = CWPU_ODIV_TAB[odiv_sel];
    assign o_main_mult_factor      = CWPU_MUL_TAB[mul_sel];
    assign o_main_mult_in_divider  = CWPU_IDIV_TAB[midiv_sel];
    // without the usb controller the multiplier stays bypassed at ratio 1
    assign o_usb_mult_bypass     = HAS_USB ? w2_r[CWPU_UBYP_BIT] : 1'b1;
    assign o_usb_mult_in_divider = HAS_USB ? CWPU_IDIV_TAB[uidiv_sel]
                                           : CWPU_IDIV_TAB[0];

    assign o_bus_power_pin_owner  = w3_r[CWPU_VBUS_BIT];
    assign o_cable_id_pin_owner   = w3_r[CWPU_CID_BIT];
    assign o_remap_single_config  = w3_r[CWPU_REMAP1_BIT];
    assign o_moddis_single_config = w3_r[CWPU_MODDIS1_BIT];
    assign o_user_identifier      = w3_r[CWPU_UID_LSB +: CWPU_UID_W];

    // lock bits: once set in single-config mode they cannot be cleared
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            remap_lock_r <= 1'b0;
            remap_used_r <= 1'b0;
        end
        else if (i_remap_lock_wr && !(o_remap_single_config && remap_used_r))
        begin
            remap_lock_r <= i_remap_lock_val;
            remap_used_r <= remap_used_r | i_remap_lock_val;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            moddis_lock_r <= 1'b0;
            moddis_used_r <= 1'b0;
        end
        else if (i_moddis_lock_wr && !(o_moddis_single_config && moddis_used_r))
        begin
            moddis_lock_r <= i_moddis_lock_val;
            moddis_used_r <= moddis_used_r | i_moddis_lock_val;
        end
    end

    assign o_remap_lock          = remap_lock_r;
    assign o_module_disable_lock = moddis_lock_r;
    assign o_remap_wr_ok  = i_remap_wr  && !remap_lock_r;
    assign o_moddis_wr_ok = i_moddis_wr && !moddis_lock_r;
endmodule

// file: test/cwpu_prog.sv
// cwpu_prog: programmer model, fills reserved word positions with ones.
// assumes the bench supplies raw words and holds them across reset.
`timescale 1ns/1ps
module cwpu_prog
(
    input  wire logic [31:0] i_raw_clk,
    input  wire logic [31:0] i_raw_pins,
    output logic      [31:0] o_word_clk,
    output logic      [31:0] o_word_pins
);
    assign o_word_clk  = i_raw_clk | 32'hfff8_7888;
    assign o_word_pins = i_raw_pins | 32'h0fff_0000;
endmodule

// file: test/cwpu_core_chk.sv
// cwpu_core_chk: port-level checks of the config decoder.
// assumes a single clock domain; bound into every cwpu_core.
`timescale 1ns/1ps
module cwpu_core_chk
    import cwpu_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic        i_remap_lock_wr,
    input wire logic        i_remap_lock_val,
    input wire logic        i_remap_wr,
    input wire logic        i_moddis_wr,
    input wire logic        o_cfg_valid,
    input wire logic [31:0] o_config_word_clock_multipliers,
    input wire logic [31:0] o_config_word_usb_pins_locks_user_identifier,
    input wire cwpu_ratio_t o_main_mult_out_divisor,
    input wire logic        o_bus_power_pin_owner,
    input wire logic [15:0] o_user_identifier,
    input wire logic        o_remap_lock,
    input wire logic        o_module_disable_lock,
    input wire logic        o_remap_wr_ok,
    input wire logic        o_moddis_wr_ok
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    a_odiv_table: assert property (o_cfg_valid |-> o_main_mult_out_divisor ==
        CWPU_ODIV_TAB[o_config_word_clock_multipliers[18:16]]) else $error("odiv bad");
    a_bus_owner: assert property (o_cfg_valid |->
        o_bus_power_pin_owner == o_config_word_usb_pins_locks_user_identifier[31]) else $error("vb");
    a_uid_copy: assert property (o_cfg_valid |->
        o_user_identifier == o_config_word_usb_pins_locks_user_identifier[15:0]) else $error("uid");
    a_remap_gate: assert property (o_remap_wr_ok ==
        (i_remap_wr && !o_remap_lock)) else $error("remap gate");
    a_moddis_gate: assert property (o_moddis_wr_ok ==
        (i_moddis_wr && !o_module_disable_lock)) else $error("moddis gate");
    a_lock_set: assert property (i_remap_lock_wr && i_remap_lock_val
        |=> o_remap_lock) else $error("lock set");
    a_clk_hold: assert property (o_cfg_valid |=>
        $stable(o_config_word_clock_multipliers)) else $error("word1 moved");
    a_pins_hold: assert property (o_cfg_valid |=>
        $stable(o_config_word_usb_pins_locks_user_identifier)) else $error("word2 moved");
    c_refused: cover property (o_remap_lock && i_remap_wr);
    c_mod_refused: cover property (o_module_disable_lock && i_moddis_wr);
    c_loaded: cover property ($rose(o_cfg_valid));
endmodule
bind cwpu_core cwpu_core_chk u_chk (.*);

// file: test/testbench.sv
// testbench: random words per reset, decode tables and lock gating.
// assumes cwpu_core, cwpu_prog and the bound checker are compiled.
`timescale 1ns/1ps
module testbench;
    import cwpu_pkg::*;
    logic        clk = 0, rst_n = 0, lw = 0, lv = 0, w = 0;
    logic [31:0] rc = 0, rp = 0, wc, wp, cw, pw;
    logic [8:0]  odv, mul, mdv, udv;
    logic        byp, vb, cid, rs, ms, rl, ml, rok, mok, cv, byp0;
    logic [8:0]  udv0;
    logic [15:0] uid;
    int          num_errors = 0, checks_done = 0;
    cwpu_prog u_prog (.i_raw_clk(rc), .i_raw_pins(rp), .o_word_clk(wc), .o_word_pins(wp));
    cwpu_core uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cfg_word_clk(wc),
        .i_cfg_word_pins(wp), .i_remap_lock_wr(lw), .i_remap_lock_val(lv),
        .i_moddis_lock_wr(lw), .i_moddis_lock_val(lv), .i_remap_wr(w), .i_moddis_wr(w),
        .o_cfg_valid(cv), .o_config_word_clock_multipliers(cw),
        .o_config_word_usb_pins_locks_user_identifier(pw), .o_main_mult_out_divisor(odv),
        .o_main_mult_factor(mul), .o_main_mult_in_divider(mdv), .o_usb_mult_bypass(byp),
        .o_usb_mult_in_divider(udv), .o_bus_power_pin_owner(vb), .o_cable_id_pin_owner(cid),
        .o_remap_single_config(rs), .o_moddis_single_config(ms), .o_user_identifier(uid),
        .o_remap_lock(rl), .o_module_disable_lock(ml), .o_remap_wr_ok(rok),
        .o_moddis_wr_ok(mok));
    // variant without the usb controller: usb fields must fall back to bypass, ratio 1
    cwpu_core #(.HAS_USB(1'b0)) uut_nousb (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_cfg_word_clk(wc), .i_cfg_word_pins(wp), .i_remap_lock_wr(lw),
        .i_remap_lock_val(lv), .i_moddis_lock_wr(lw), .i_moddis_lock_val(lv),
        .i_remap_wr(w), .i_moddis_wr(w), .o_cfg_valid(),
        .o_config_word_clock_multipliers(), .o_config_word_usb_pins_locks_user_identifier(),
        .o_main_mult_out_divisor(), .o_main_mult_factor(), .o_main_mult_in_divider(),
        .o_usb_mult_bypass(byp0), .o_usb_mult_in_divider(udv0),
        .o_bus_power_pin_owner(), .o_cable_id_pin_owner(), .o_remap_single_config(),
        .o_moddis_single_config(), .o_user_identifier(), .o_remap_lock(),
        .o_module_disable_lock(), .o_remap_wr_ok(), .o_moddis_wr_ok());
    initial forever #4 clk = ~clk;
    function automatic logic [8:0] f_div(input int c);
        return (c == 7) ? 9'h00c : (c == 6) ? 9'h00a : 9'(c + 1);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(29));
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            rst_n = 0;
            rc = $urandom;
            rp = $urandom;
            {rc[18:16], rc[10:8], rc[6:4], rc[2:0]} = {4{3'(i)}};
            repeat (6) @(negedge clk);
            chk(cv, 1'b0, "valid in reset");
            chk(cw, 32'hffff_ffff, "word1 in reset");
            rst_n = 1;
            @(negedge clk);
            chk(cv, 1'b1, "valid");
            chk(byp0, 1'b1, "no usb bypass");
            chk(udv0, 9'h001, "no usb udiv");
            chk(cw, wc, "word1");
            chk(pw, wp, "word2");
            chk(odv, (i == 7) ? 9'h100 : 9'(1 << i), "odiv");
            chk(byp, rc[15], "bypass");
            chk(udv, f_div(i), "udiv");
            chk(mul, (i == 7) ? 9'h018 : 9'(15 + i), "mul");
            chk(mdv, f_div(i), "mdiv");
            chk({vb, cid, rs, ms}, rp[31:28], "owners");
            chk(uid, rp[15:0], "uid");
            lw = 1;
            lv = 1;
            @(negedge clk);
            lv = 0;
            w = 1;
            chk({rl, ml, rok, mok}, 4'hc, "locked");
            @(negedge clk);
            lw = 0;
            chk({rl, rok}, {rp[29], !rp[29]}, "remap relock");
            chk({ml, mok}, {rp[28], !rp[28]}, "mod relock");
            w = 0;
            $display("test %0d done", i);
        end
        finish_test();
    end
endmodule
